/* rtl/bst_pkg.sv */
// bst_pkg: constants and types of the boundary-scan test access port
package bst_pkg;

    // controller states, sixteen of them
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
        ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } bst_state_e;

    localparam int IR_W = 3;
    localparam int ID_W = 32;

    // instruction codes; the three unlisted codes are reserved
    localparam logic [IR_W-1:0] INS_EXTEST  = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE  = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLEZ = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE  = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS  = 3'h7;

    // pattern loaded into the instruction stage on capture
    localparam logic [IR_W-1:0] IR_CAPTURE  = 3'h1;

    // boundary ring length and the output-bus gating cell
    localparam int BSR_LEN_DEF = 109;
    localparam int BSR_OE_BIT  = 108;

    // identification value: arbitrary, bit 0 set as the standard asks
    localparam logic [ID_W-1:0] ID_CODE_DEF = 32'h0a5a_5001;

    // reset levels of the pin synchronisers (pads pull up mode and data)
    localparam logic TMS_RST = 1'h1;
    localparam logic TDI_RST = 1'h1;
    localparam logic TCK_RST = 1'h0;

endpackage

/* rtl/bst_tap.sv */
// bst_tap: boundary-scan test access port sampled on the core clock
module bst_tap #(
    parameter int                       BSR_LEN     = bst_pkg::BSR_LEN_DEF,
    parameter logic [bst_pkg::ID_W-1:0] ID_CODE     = bst_pkg::ID_CODE_DEF,
    parameter logic [BSR_LEN-1:0]       BSR_NC_MASK = '0
) (
    input  wire logic               CORE_CLK_I,
    input  wire logic               SRST_I,
    input  wire logic               TCK_I,
    input  wire logic               TMS_I,
    input  wire logic               TDI_I,
    output logic                    TDO_O,
    output logic                    TDO_OE_O,
    input  wire logic [BSR_LEN-1:0] RING_I,
    output logic      [BSR_LEN-1:0] RING_O,
    output logic                    EXTEST_O,
    input  wire logic               MEM_Q_OE_I,
    output logic                    Q_OE_O
);

    typedef struct packed {
        logic                         tck_m;
        logic                         tck_s;
        logic                         tck_p;
        logic                         tms_m;
        logic                         tms_s;
        logic                         tdi_m;
        logic                         tdi_s;
        bst_pkg::bst_state_e          st;
        logic [bst_pkg::IR_W-1:0]     ir;
        logic [bst_pkg::IR_W-1:0]     ir_sh;
        logic                         byp;
        logic [bst_pkg::ID_W-1:0]     id_sh;
        logic [BSR_LEN-1:0]           bsr_sh;
        logic [BSR_LEN-1:0]           bsr_upd;
        logic                         tdo;
        logic                         tdo_oe;
        logic                         q_oe;
    } bst_regs_s;

    bst_regs_s q;
    bst_regs_s d;

    logic tck_rise;
    logic tck_fall;
    logic sel_id;
    logic sel_bsr;

    function automatic bst_pkg::bst_state_e next_state(input bst_pkg::bst_state_e s,
                                                        input logic tms);
        bst_pkg::bst_state_e n;
        n = bst_pkg::ST_RESET;
        case (s)
            bst_pkg::ST_RESET:    n = tms ? bst_pkg::ST_RESET   : bst_pkg::ST_IDLE;
            bst_pkg::ST_IDLE:     n = tms ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_DR:   n = tms ? bst_pkg::ST_SEL_IR  : bst_pkg::ST_CAP_DR;
            bst_pkg::ST_CAP_DR:   n = tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_SHIFT_DR: n = tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_EXIT1_DR: n = tms ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_PAUSE_DR: n = tms ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_EXIT2_DR: n = tms ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_UPD_DR:   n = tms ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_IR:   n = tms ? bst_pkg::ST_RESET   : bst_pkg::ST_CAP_IR;
            bst_pkg::ST_CAP_IR:   n = tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_SHIFT_IR: n = tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_EXIT1_IR: n = tms ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_PAUSE_IR: n = tms ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_EXIT2_IR: n = tms ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_UPD_IR:   n = tms ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
            default:              n = bst_pkg::ST_RESET;
        endcase
        return n;
    endfunction

    // edges of the test clock, seen after the synchroniser
    assign tck_rise = q.tck_s & ~q.tck_p;
    assign tck_fall = ~q.tck_s & q.tck_p;

    // register selection by the current instruction; reserved codes act as bypass
    assign sel_id  = (q.ir == bst_pkg::INS_IDCODE);
    assign sel_bsr = (q.ir == bst_pkg::INS_EXTEST) || (q.ir == bst_pkg::INS_SAMPLE)
                  || (q.ir == bst_pkg::INS_SAMPLEZ);

    always_comb begin
        d       = q;
        d.tck_m = TCK_I;
        d.tck_s = q.tck_m;
        d.tck_p = q.tck_s;
        d.tms_m = TMS_I;
        d.tms_s = q.tms_m;
        d.tdi_m = TDI_I;
        d.tdi_s = q.tdi_m;

        if (tck_rise) begin
            d.st = next_state(q.st, q.tms_s);
            case (q.st)
                bst_pkg::ST_CAP_IR: begin
                    d.ir_sh = bst_pkg::IR_CAPTURE;
                end
                bst_pkg::ST_SHIFT_IR: begin
                    d.ir_sh = {q.tdi_s, q.ir_sh[bst_pkg::IR_W-1:1]};
                end
                bst_pkg::ST_UPD_IR: begin
                    d.ir = q.ir_sh;
                end
                bst_pkg::ST_CAP_DR: begin
                    if (sel_id) begin
                        d.id_sh = ID_CODE;
                    end else if (sel_bsr) begin
                        // unconnected-ball cells capture zero
                        d.bsr_sh = RING_I & ~BSR_NC_MASK;
                    end else begin
                        d.byp = 1'b0;
                    end
                end
                bst_pkg::ST_SHIFT_DR: begin
                    if (sel_id) begin
                        d.id_sh = {q.tdi_s, q.id_sh[bst_pkg::ID_W-1:1]};
                    end else if (sel_bsr) begin
                        d.bsr_sh = {q.tdi_s, q.bsr_sh[BSR_LEN-1:1]};
                    end else begin
                        d.byp = q.tdi_s;
                    end
                end
                bst_pkg::ST_UPD_DR: begin
                    if ((q.ir == bst_pkg::INS_SAMPLE) || (q.ir == bst_pkg::INS_EXTEST)) begin
                        d.bsr_upd = q.bsr_sh;
                    end
                end
                default: begin
                    d.ir_sh = q.ir_sh;
                end
            endcase
            if (d.st == bst_pkg::ST_RESET) begin
                d.ir                      = bst_pkg::INS_IDCODE;
                d.bsr_upd[bst_pkg::BSR_OE_BIT] = 1'b1;
            end
        end

        if (tck_fall) begin
            d.tdo_oe = (q.st == bst_pkg::ST_SHIFT_DR) || (q.st == bst_pkg::ST_SHIFT_IR);
            if (q.st == bst_pkg::ST_SHIFT_IR) begin
                d.tdo = q.ir_sh[0];
            end else if (sel_id) begin
                d.tdo = q.id_sh[0];
            end else if (sel_bsr) begin
                d.tdo = q.bsr_sh[0];
            end else begin
                d.tdo = q.byp;
            end
        end

        // memory output bus: functional enable unless a test instruction overrides
        if (q.ir == bst_pkg::INS_SAMPLEZ) begin
            d.q_oe = 1'b0;
        end else if (q.ir == bst_pkg::INS_EXTEST) begin
            d.q_oe = q.bsr_upd[bst_pkg::BSR_OE_BIT];
        end else begin
            d.q_oe = MEM_Q_OE_I;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            q                          <= '0;
            q.tck_m                    <= bst_pkg::TCK_RST;
            q.tck_s                    <= bst_pkg::TCK_RST;
            q.tck_p                    <= bst_pkg::TCK_RST;
            q.tms_m                    <= bst_pkg::TMS_RST;
            q.tms_s                    <= bst_pkg::TMS_RST;
            q.tdi_m                    <= bst_pkg::TDI_RST;
            q.tdi_s                    <= bst_pkg::TDI_RST;
            q.st                       <= bst_pkg::ST_RESET;
            q.ir                       <= bst_pkg::INS_IDCODE;
            q.bsr_upd[bst_pkg::BSR_OE_BIT] <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign TDO_O    = q.tdo;
    assign TDO_OE_O = q.tdo_oe;
    assign RING_O   = q.bsr_upd;
    assign EXTEST_O = (q.ir == bst_pkg::INS_EXTEST);
    assign Q_OE_O   = q.q_oe;

    // count of consecutive test-clock rises with mode select high
    logic [2:0] tms_hi_cnt;
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            tms_hi_cnt <= 3'h0;
        end else if (tck_rise) begin
            if (!q.tms_s) begin
                tms_hi_cnt <= 3'h0;
            end else if (tms_hi_cnt != 3'h7) begin
                tms_hi_cnt <= tms_hi_cnt + 3'h1;
            end
        end
    end

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (SRST_I);

    a_tdo_on_fall: assert property ($changed(TDO_O) |-> $past(tck_fall))
        else $error("serial output changed away from a test-clock fall");

    a_oe_on_fall: assert property ($changed(TDO_OE_O) |-> $past(tck_fall))
        else $error("serial output enable changed away from a test-clock fall");

    a_oe_shift_only: assert property (
        (tck_fall && q.st != bst_pkg::ST_SHIFT_DR && q.st != bst_pkg::ST_SHIFT_IR)
        |=> !TDO_OE_O)
        else $error("serial output driven outside a shift state");

    a_five_high_reset: assert property ((tms_hi_cnt >= 3'h5) |-> q.st == bst_pkg::ST_RESET)
        else $error("five high mode edges did not reach reset");

    a_reset_idcode: assert property ((q.st == bst_pkg::ST_RESET)
        |-> (q.ir == bst_pkg::INS_IDCODE) && q.bsr_upd[bst_pkg::BSR_OE_BIT])
        else $error("reset state without identification instruction or gating preset");

    a_capir_pattern: assert property ((tck_rise && q.st == bst_pkg::ST_CAP_IR)
        |=> q.ir_sh == bst_pkg::IR_CAPTURE)
        else $error("instruction capture did not load 01");

    a_ir_update_only: assert property ($changed(q.ir)
        |-> ($past(q.st) == bst_pkg::ST_UPD_IR) || (q.st == bst_pkg::ST_RESET))
        else $error("instruction changed outside update or reset");

    a_bypass_zero: assert property ((tck_rise && q.st == bst_pkg::ST_CAP_DR && !sel_id && !sel_bsr)
        |=> !q.byp)
        else $error("bypass bit not cleared on capture");

    a_id_capture: assert property ((tck_rise && q.st == bst_pkg::ST_CAP_DR && sel_id)
        |=> q.id_sh == ID_CODE)
        else $error("identification value not captured");

    a_shift_msb: assert property ((tck_rise && q.st == bst_pkg::ST_SHIFT_DR && sel_bsr)
        |=> q.bsr_sh[BSR_LEN-1] == $past(q.tdi_s))
        else $error("serial data did not enter at the top bit");

    a_samplez_float: assert property ((q.ir == bst_pkg::INS_SAMPLEZ) |=> !Q_OE_O)
        else $error("memory outputs enabled under high-impedance sample");

    a_extest_gate: assert property ((q.ir == bst_pkg::INS_EXTEST)
        |=> Q_OE_O == $past(q.bsr_upd[bst_pkg::BSR_OE_BIT]))
        else $error("output gating cell ignored under extest");

    // shift paths: each selected register takes the data pin at its top bit
    a_byp_shift: assert property ((tck_rise && q.st == bst_pkg::ST_SHIFT_DR && !sel_id && !sel_bsr)
        |=> q.byp == $past(q.tdi_s))
        else $error("bypass bit did not take the data pin");

    a_id_shift: assert property ((tck_rise && q.st == bst_pkg::ST_SHIFT_DR && sel_id)
        |=> q.id_sh[bst_pkg::ID_W-1] == $past(q.tdi_s))
        else $error("identification shift did not enter at the top bit");

    a_ir_shift: assert property ((tck_rise && q.st == bst_pkg::ST_SHIFT_IR)
        |=> q.ir_sh[bst_pkg::IR_W-1] == $past(q.tdi_s))
        else $error("instruction shift did not enter at the top bit");

    a_ring_capture: assert property ((tck_rise && q.st == bst_pkg::ST_CAP_DR && sel_bsr)
        |=> q.bsr_sh == $past(RING_I & ~BSR_NC_MASK))
        else $error("boundary ring snapshot not taken on capture");

    a_ir_update_load: assert property ((tck_rise && q.st == bst_pkg::ST_UPD_IR)
        |=> q.ir == $past(q.ir_sh))
        else $error("instruction stage not made current on update");

    a_ring_update: assert property ((tck_rise && q.st == bst_pkg::ST_UPD_DR
        && ((q.ir == bst_pkg::INS_SAMPLE) || (q.ir == bst_pkg::INS_EXTEST)))
        |=> RING_O == $past(q.bsr_sh))
        else $error("update latch did not take the shifted ring");

    // output side: the bit at the bottom of the selected register
    a_tdo_id_bit: assert property ((tck_fall && q.st == bst_pkg::ST_SHIFT_DR && sel_id)
        |=> (TDO_O == $past(q.id_sh[0])) && TDO_OE_O)
        else $error("serial output not the identification bottom bit");

    a_tdo_ir_bit: assert property ((tck_fall && q.st == bst_pkg::ST_SHIFT_IR)
        |=> (TDO_O == $past(q.ir_sh[0])) && TDO_OE_O)
        else $error("serial output not the instruction stage bottom bit");

    a_tdo_byp_bit: assert property ((tck_fall && q.st == bst_pkg::ST_SHIFT_DR
        && !sel_id && !sel_bsr)
        |=> TDO_O == $past(q.byp))
        else $error("serial output not the bypass bit");

    a_oe_in_shift: assert property ((tck_fall
        && (q.st == bst_pkg::ST_SHIFT_DR || q.st == bst_pkg::ST_SHIFT_IR))
        |=> TDO_OE_O)
        else $error("serial output not driven in a shift state");

    a_reset_tdo_off: assert property ((tck_fall && q.st == bst_pkg::ST_RESET)
        |=> !TDO_OE_O)
        else $error("serial output driven in the reset state");

    a_functional_oe: assert property ((q.ir != bst_pkg::INS_SAMPLEZ && q.ir != bst_pkg::INS_EXTEST)
        |=> Q_OE_O == $past(MEM_Q_OE_I))
        else $error("memory output enable disturbed by the test port");

    a_state_hold: assert property (!tck_rise |=> $stable(q.st))
        else $error("controller moved without a test-clock rise");

    a_reset_cell: assert property ((tck_rise && q.st == bst_pkg::ST_SEL_IR && q.tms_s)
        |=> q.bsr_upd[bst_pkg::BSR_OE_BIT])
        else $error("gating cell not preset on entry to reset");

    c_id_shift: cover property (q.st == bst_pkg::ST_SHIFT_DR && sel_id && TDO_OE_O);
    c_ir_update: cover property (tck_rise && q.st == bst_pkg::ST_UPD_IR);
    c_bypass_shift: cover property (q.st == bst_pkg::ST_SHIFT_DR && q.ir == bst_pkg::INS_BYPASS);
    c_ring_shift: cover property (q.st == bst_pkg::ST_SHIFT_DR && sel_bsr && TDO_OE_O);
    c_tms_reset: cover property (q.st != bst_pkg::ST_RESET ##[1:1000] q.st == bst_pkg::ST_RESET);

endmodule

/* sim/bst_ctl_model.sv */
// bst_ctl_model: behavioural boundary-scan controller driving the test port
module bst_ctl_model (
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // test clock stands low outside frames, released lines sit at pull-up level
    initial begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h1;
    end

    // one test clock: set up after the fall, sample the pin at the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #62.5;
        tdo = tdo_i;
        tck_o = 1'h1;
        #62.5;
        tck_o = 1'h0;
    endtask

    // five high mode rises reach reset from any state, then idle
    task automatic reset5();
        logic d;
        repeat (5) step(1'h1, 1'h1, d);
        step(1'h0, 1'h1, d);
        tms_o = 1'h1;
    endtask

    // from idle: capture, shift n bits lsb first, stop in exit1
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic d;
        dout = '0;
        step(1'h1, 1'h1, d);
        if (ir) step(1'h1, 1'h1, d);
        step(1'h0, 1'h1, d);
        step(1'h0, 1'h1, d);
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    endtask

    // update then idle
    task automatic finish();
        logic d;
        step(1'h1, 1'h1, d);
        step(1'h0, 1'h1, d);
        tms_o = 1'h1;
        tdi_o = 1'h1;
    endtask
endmodule

/* sim/sram_boundary_scan_tap_test.sv */
// sram_boundary_scan_tap_test: self-checking bench of the test access port
module sram_boundary_scan_tap_test;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int L = bst_pkg::BSR_LEN_DEF;

    logic           clk    = 1'h0;
    logic           srst   = 1'h1;
    logic           mem_oe = 1'h1;
    logic [L-1:0]   ring   = '0;
    logic [L-1:0]   ring_o;
    logic [L-1:0]   latch;
    logic           tdo;
    logic           tdo_oe;
    logic           extest;
    logic           q_oe;
    wire            tck;
    wire            tms;
    wire            tdi;
    wire            tdo_pin = tdo_oe ? tdo : 1'bz;
    int             n_errors = 0;
    int             n_checks = 0;
    int             cyc = 0;
    int             seed = 87;
    logic [127:0]   din;
    logic [127:0]   dout;
    logic [2:0]     prev;
    // only implemented codes are ever loaded
    logic [2:0]     codes[3] = '{bst_pkg::INS_SAMPLE, bst_pkg::INS_EXTEST,
                                 bst_pkg::INS_SAMPLEZ};

    always #5 clk = ~clk;

    bst_tap DUT (.CORE_CLK_I(clk), .SRST_I(srst), .TCK_I(tck), .TMS_I(tms),
                 .TDI_I(tdi), .TDO_O(tdo), .TDO_OE_O(tdo_oe), .RING_I(ring),
                 .RING_O(ring_o), .EXTEST_O(extest), .MEM_Q_OE_I(mem_oe),
                 .Q_OE_O(q_oe));

    bst_ctl_model ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_pin));

    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic [127:0] rnd();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction

    function automatic logic [15:0] byp_exp(logic [127:0] d);
        return {d[14:0], 1'h0};
    endfunction

    function automatic logic qexp(logic [2:0] c);
        return (c == bst_pkg::INS_SAMPLEZ) ? 1'h0 :
               (c == bst_pkg::INS_EXTEST) ? latch[bst_pkg::BSR_OE_BIT] : mem_oe;
    endfunction

    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic read_id();
        ctl.scan(1'h0, 32, rnd(), dout);
        ctl.finish();
        settle();
        chk("idcode", dout[31:0], bst_pkg::ID_CODE_DEF);
        chk("tdo_oe idle", tdo_oe, 1'h0);
        $display("test idcode done");
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    initial begin
        latch = '0;
        latch[bst_pkg::BSR_OE_BIT] = 1'h1;
        repeat (5) @(posedge clk);
        #1;
        srst = 1'h0;
        settle();
        chk("tdo_oe reset", tdo_oe, 1'h0);
        chk("q_oe reset", q_oe, mem_oe);
        // leave the reset state for idle before the first scan
        ctl.reset5();
        read_id();
        ctl.scan(1'h1, 3, {125'h0, bst_pkg::INS_BYPASS}, dout);
        ctl.finish();
        chk("ir capture", dout[2:0], bst_pkg::IR_CAPTURE);
        din = rnd();
        ctl.scan(1'h0, 16, din, dout);
        ctl.finish();
        chk("bypass", dout[15:0], byp_exp(din));
        $display("test bypass done");
        prev = bst_pkg::INS_BYPASS;
        for (int k = 0; k < 3; k++) begin
            ctl.scan(1'h1, 3, {125'h0, codes[k]}, dout);
            settle();
            chk("extest before update", extest, prev == bst_pkg::INS_EXTEST);
            ctl.finish();
            settle();
            chk("q_oe after ir", q_oe, qexp(codes[k]));
            ring = rnd();
            mem_oe = 1'($random(seed));
            din = rnd();
            din[bst_pkg::BSR_OE_BIT] = k[0];
            ctl.scan(1'h0, L, din, dout);
            ctl.finish();
            settle();
            if (codes[k] != bst_pkg::INS_SAMPLEZ) latch = din[L-1:0];
            chk("ring capture", dout[L-1:0], ring);
            chk("ring update", ring_o, latch);
            chk("q_oe", q_oe, qexp(codes[k]));
            chk("extest", extest, codes[k] == bst_pkg::INS_EXTEST);
            prev = codes[k];
            $display("test ring code %0d done", k);
        end
        // mode reset from the middle of a data scan
        ctl.scan(1'h0, 5, rnd(), dout);
        ctl.reset5();
        settle();
        chk("extest after reset", extest, 1'h0);
        chk("gate cell preset", ring_o[bst_pkg::BSR_OE_BIT], 1'h1);
        chk("q_oe after reset", q_oe, mem_oe);
        read_id();
        end_of_test();
    end
endmodule
